/* src/tcf_defs.vh */
// register map, field positions and reset values of the capture flag timer block
`ifndef TCF_DEFS_VH
`define TCF_DEFS_VH

`define TCF_ADDR_W 8
`define TCF_STATUS_BASE 8'h00
`define TCF_COUNTER_BASE 8'h20
`define TCF_EVENT_ENABLE 8'h40
`define TCF_IRQ_STATUS 8'h44
`define TCF_IRQ_MASK 8'h48

`define TCF_FLAG_A 0
`define TCF_FLAG_B 1
`define TCF_FLAG_C 2
`define TCF_FLAG_D 3
`define TCF_STATUS_FIXED_ONES 8'hC0
`define TCF_COUNTER_RESET 16'h0000
`define TCF_CHANNELS 6
`define TCF_FLAGS_PER_CH 4
`define TCF_FULL_CH_A 0
`define TCF_FULL_CH_B 3

`endif

/* src/tcf_timer_capture_flags.v */
// capture/compare flags and up-counters of a six-channel pulse timer, wishbone slave
`timescale 1ns/1ns
// Overview of operation
// - flag D set on compare match
// - flag D set on input capture
// - bit 3 reserved in narrow channels
// - flag C set on compare, channels 0,3
// - flag C set on input capture
// - bit 2 reserved in narrow channels
// - flag B set on compare match
// - flag B set on input capture
// - flag A set on compare match
// - flag A set on input capture
// - flags reset to zero; writing one ignored
// - clear needs read of one, then zero
// - transfer controller service clears flag unless suppressed
// - six 16-bit readable writable up-counters
// - counters zero on reset and standby
// - event request is flag and enable
`include "tcf_defs.vh"

module tcf_timer_capture_flags #(
  parameter NCH = `TCF_CHANNELS,
  parameter CW = 16
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_standby,
  input wire [`TCF_ADDR_W-1:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  input wire i_wb_we,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire [NCH-1:0] i_count_enable,
  input wire [NCH*4*CW-1:0] i_general_reg,
  input wire [NCH*4-1:0] i_capture_mode,
  input wire [NCH*4-1:0] i_capture_strobe,
  input wire [NCH*4-1:0] i_xfer_activate,
  input wire [NCH*4-1:0] i_clear_suppress_select,
  output wire [NCH*4-1:0] o_event_request,
  output wire [NCH*4-1:0] o_capture_compare_flag,
  output wire [NCH*CW-1:0] o_timer_channel_counter,
  output wire o_irq
);

  localparam NF = NCH * `TCF_FLAGS_PER_CH;
  // one-hot states of the bus answer
  localparam [1:0] BUS_IDLE = 2'b01;
  localparam [1:0] BUS_ACK = 2'b10;
  // whole-word control registers, one bit per flag slot
  localparam [`TCF_ADDR_W-1:0] ADR_ENABLE = `TCF_EVENT_ENABLE;
  localparam [`TCF_ADDR_W-1:0] ADR_IRQ_STATUS = `TCF_IRQ_STATUS;
  localparam [`TCF_ADDR_W-1:0] ADR_IRQ_MASK = `TCF_IRQ_MASK;

  reg [NF-1:0] flag_reg;
  reg [NF-1:0] flag_next;
  reg [NF-1:0] read_seen_reg;
  reg [NF-1:0] read_seen_next;
  reg [NF-1:0] event_enable_reg;
  reg [NF-1:0] irq_status_reg;
  reg [NF-1:0] irq_mask_reg;
  reg [CW-1:0] counter_reg [0:NCH-1];
  reg [31:0] rdata_next;
  reg [NF-1:0] event_enable_next;
  reg [NF-1:0] irq_mask_next;
  reg [31:0] wb_dat_next;
  reg wb_ack_next;
  reg [1:0] bus_state_reg;
  reg [1:0] bus_state_next;
  wire [NF-1:0] irq_status_next;
  wire [NF-1:0] cmp_set;
  wire [NF-1:0] cap_set;
  wire [NF-1:0] sw_clear;
  wire [NF-1:0] xfer_clear;
  wire [NCH-1:0] status_hit;
  wire [31:0] ch_rdata [0:NCH-1];
  wire [NF-1:0] flag_valid;
  wire [NF-1:0] flag_set;
  wire [NF-1:0] status_read;
  wire [NF-1:0] status_write_zero;
  wire [NCH-1:0] counter_changed;
  wire [CW-1:0] counter_next [0:NCH-1];

  // a bus access is acted on once, in the cycle before ack rises
  wire bus_go = i_wb_cyc & i_wb_stb & bus_state_reg[0];
  wire bus_wr = bus_go & i_wb_we;
  wire bus_rd = bus_go & ~i_wb_we;
  wire full_word16 = (i_wb_sel[1:0] == 2'b11);
  // whole-word register decode
  wire enable_hit = (i_wb_adr == ADR_ENABLE);
  wire irq_status_hit = (i_wb_adr == ADR_IRQ_STATUS);
  wire irq_mask_hit = (i_wb_adr == ADR_IRQ_MASK);

  // per channel counter, written only as a full 16-bit unit
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      // address words of this channel, cut to the bus address width on purpose
      localparam [31:0] CNT_ADR_W = `TCF_COUNTER_BASE + c * 4;
      localparam [31:0] STS_ADR_W = `TCF_STATUS_BASE + c * 4;
      wire hit_cnt = (i_wb_adr == CNT_ADR_W[`TCF_ADDR_W-1:0]);
      wire hit_sts = (i_wb_adr == STS_ADR_W[`TCF_ADDR_W-1:0]);
      // a byte-wide write would tear the count, so it is acked and dropped
      wire wr_cnt = bus_wr & hit_cnt & full_word16;
      wire [CW-1:0] count_plus = counter_reg[c] + 1'b1;
      wire [CW-1:0] count_hold = i_count_enable[c] ? count_plus : counter_reg[c];
      wire [7:0] status_byte = `TCF_STATUS_FIXED_ONES | {4'h0, flag_reg[c*4 +: 4]};

      // a bus write wins over the increment of the same cycle
      assign counter_next[c] = wr_cnt ? i_wb_dat[CW-1:0] : count_hold;
      assign counter_changed[c] = (counter_next[c] != counter_reg[c]);
      assign o_timer_channel_counter[c*CW +: CW] = counter_reg[c];
      assign status_hit[c] = hit_sts;

      // read word of this channel; zero unless one of its addresses is hit
      assign ch_rdata[c] = hit_sts ? {24'h000000, status_byte} :
        (hit_cnt ? {{(32-CW){1'b0}}, counter_reg[c]} : 32'h00000000);

      // standby clears like reset but leaves flags and control alone
      always @(posedge i_clock) begin
        if (i_rst || i_standby) begin
          counter_reg[c] <= `TCF_COUNTER_RESET;
        end else begin
          counter_reg[c] <= counter_next[c];
        end
      end
    end
  endgenerate

  // per flag set and clear terms; c and d exist only in wide channels
  genvar k;
  generate
    for (k = 0; k < NF; k = k + 1) begin : g_flag
      localparam CH = k / 4;
      localparam FB = k % 4;
      wire [CW-1:0] greg = i_general_reg[k*CW +: CW];
      // compare only when the counter moves onto the value, so a stopped
      // counter sitting on the compare value does not keep re-setting the flag
      wire cmp_hit = ~i_capture_mode[k] & counter_changed[CH] & (counter_next[CH] == greg);
      // the capture strobe marks the copy of the count into the general register
      wire cap_hit = i_capture_mode[k] & i_capture_strobe[k];
      // narrow channels have no c and d slots; those bits never set
      assign flag_valid[k] = (FB < 2) || (CH == `TCF_FULL_CH_A) || (CH == `TCF_FULL_CH_B);
      assign cmp_set[k] = flag_valid[k] & cmp_hit;
      assign cap_set[k] = flag_valid[k] & cap_hit;
      assign flag_set[k] = cmp_set[k] | cap_set[k];
      // only the status byte of this flag's own channel arms or clears it
      assign status_read[k] = bus_rd & status_hit[CH];
      // writing one is a no-op; only a zero in the selected byte clears
      assign status_write_zero[k] = bus_wr & status_hit[CH] & i_wb_sel[0] &
        ~i_wb_dat[FB];
    end
  endgenerate

  // the two clearing paths, kept apart so each can be watched on its own
  assign sw_clear = status_write_zero & read_seen_reg;
  assign xfer_clear = i_xfer_activate & ~i_clear_suppress_select & flag_reg;

  // flag update: set wins over either clearing path, so no event is lost
  always @* begin
    flag_next = flag_reg;
    read_seen_next = read_seen_reg;
    // a read only arms bits that show one at that moment
    read_seen_next = read_seen_next | (status_read & flag_reg);
    flag_next = flag_next & ~sw_clear;
    read_seen_next = read_seen_next & ~sw_clear;
    flag_next = flag_next & ~xfer_clear;
    flag_next = (flag_next | flag_set) & flag_valid;
    // a cleared flag must be read as one again before the next clear
    read_seen_next = read_seen_next & flag_next;
  end

  // flag and seen registers
  always @(posedge i_clock) begin
    if (i_rst) begin
      flag_reg <= {NF{1'b0}};
      read_seen_reg <= {NF{1'b0}};
    end else begin
      flag_reg <= flag_next;
      read_seen_reg <= read_seen_next;
    end
  end

  // event request toward interrupt logic and transfer controller
  assign o_event_request = flag_reg & event_enable_reg;
  assign o_capture_compare_flag = flag_reg;

  // enable and mask take a whole word; slots that do not exist stay zero
  always @* begin
    event_enable_next = event_enable_reg;
    irq_mask_next = irq_mask_reg;
    if (bus_wr && enable_hit) begin
      event_enable_next = i_wb_dat[NF-1:0] & flag_valid;
    end
    if (bus_wr && irq_mask_hit) begin
      irq_mask_next = i_wb_dat[NF-1:0] & flag_valid;
    end
  end

  // sticky interrupt status, one bit per slot, write one to clear
  genvar s;
  generate
    for (s = 0; s < NF; s = s + 1) begin : g_irq
      wire clr = bus_wr & irq_status_hit & i_wb_dat[s];
      // a new event in the clearing cycle stays recorded
      assign irq_status_next[s] = flag_set[s] | (irq_status_reg[s] & ~clr);
    end
  endgenerate

  // event enable register
  always @(posedge i_clock) begin
    if (i_rst) begin
      event_enable_reg <= {NF{1'b0}};
    end else begin
      event_enable_reg <= event_enable_next;
    end
  end

  // interrupt mask register
  always @(posedge i_clock) begin
    if (i_rst) begin
      irq_mask_reg <= {NF{1'b0}};
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  // interrupt status register
  always @(posedge i_clock) begin
    if (i_rst) begin
      irq_status_reg <= {NF{1'b0}};
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // level interrupt; one unmasked sticky bit is enough
  assign o_irq = |(irq_status_reg & irq_mask_reg);

  // read mux; unmapped addresses answer zero
  integer i;
  always @* begin
    rdata_next = 32'h00000000;
    // each channel word is zero unless its own address is hit
    for (i = 0; i < NCH; i = i + 1) begin
      rdata_next = rdata_next | ch_rdata[i];
    end
    if (enable_hit) begin
      rdata_next[NF-1:0] = event_enable_reg;
    end
    if (irq_status_hit) begin
      rdata_next[NF-1:0] = irq_status_reg;
    end
    if (irq_mask_hit) begin
      rdata_next[NF-1:0] = irq_mask_reg;
    end
  end

  // bus answer: one wait state, ack for one cycle, then back to idle
  always @* begin
    bus_state_next = bus_state_reg;
    wb_ack_next = 1'b0;
    wb_dat_next = o_wb_dat;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (i_wb_cyc && i_wb_stb) begin
          bus_state_next = BUS_ACK;
          wb_ack_next = 1'b1;
        end
        if (bus_rd) begin
          // read data is caught with the access, so it stands with ack
          wb_dat_next = rdata_next;
        end
      end
      BUS_ACK: begin
        // ack is never held: the master drops cyc and stb after seeing it
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  // bus registers
  always @(posedge i_clock) begin
    if (i_rst) begin
      bus_state_reg <= BUS_IDLE;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      bus_state_reg <= bus_state_next;
      o_wb_ack <= wb_ack_next;
      o_wb_dat <= wb_dat_next;
    end
  end

endmodule // tcf_timer_capture_flags

/* test/tcf_host_model.sv */
// cpu bus master standing in front of the capture flag timer
`timescale 1ns/1ns
module tcf_host_model (
  input wire i_clock,
  input wire i_ack,
  input wire [31:0] i_rdat,
  output reg o_cyc = 1'b0,
  output reg o_stb = 1'b0,
  output reg o_we = 1'b0,
  output reg [7:0] o_adr = 8'h00,
  output reg [3:0] o_sel = 4'h0,
  output reg [31:0] o_dat = 32'h0
);
  integer timeouts = 0;
  // one classic cycle; bounded wait so a dead slave cannot hang the run
  task xfer(input [7:0] a, input w, input [3:0] s, input [31:0] d, output [31:0] q);
    integer n;
    begin
      n = 0;
      {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, w, a, s, d};
      do begin
        @(posedge i_clock);
        n = n + 1;
      end while (i_ack !== 1'b1 && n < 40);
      if (n >= 40) timeouts = timeouts + 1;
      q = i_rdat;
      {o_cyc, o_stb, o_dat} <= {2'b00, ~d}; // stale data must not look valid
      @(posedge i_clock);
    end
  endtask
endmodule // tcf_host_model

/* test/tcf_props.sv */
// port assertions for the capture flag timer
`timescale 1ns/1ns
module tcf_props (
  input wire i_clock,
  input wire i_rst,
  input wire i_standby,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire o_wb_ack,
  input wire [23:0] i_capture_strobe,
  input wire [23:0] i_capture_mode,
  input wire [23:0] i_xfer_activate,
  input wire [23:0] o_event_request,
  input wire [23:0] o_capture_compare_flag,
  input wire [95:0] o_timer_channel_counter
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence req_s; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
  ack_answer_a: assert property (req_s |=> o_wb_ack) else $error("ack late");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack long");
  reset_flags_a: assert property (disable iff (1'b0) i_rst |=> !o_capture_compare_flag)
    else $error("flag after reset");
  capture_set_a: assert property ((i_capture_strobe & i_capture_mode) != 0 |=>
    ($past(i_capture_strobe & i_capture_mode) & 24'h33F33F & ~o_capture_compare_flag) == 0)
    else $error("capture lost");
  reserved_zero_a: assert property ((o_capture_compare_flag & 24'hCC0CC0) == 0)
    else $error("reserved flag");
  request_gate_a: assert property ((o_event_request & ~o_capture_compare_flag) == 0)
    else $error("request without flag");
  flag_hold_a: assert property (!i_wb_cyc |=>
    ($past(o_capture_compare_flag & ~i_xfer_activate) & ~o_capture_compare_flag) == 0)
    else $error("flag dropped");
  standby_zero_a: assert property (i_standby |=> o_timer_channel_counter == 96'h0)
    else $error("counter in standby");
endmodule // tcf_props
bind tcf_timer_capture_flags tcf_props props_u (.i_clock, .i_rst, .i_standby, .i_wb_cyc,
  .i_wb_stb, .o_wb_ack, .i_capture_strobe, .i_capture_mode, .i_xfer_activate,
  .o_event_request, .o_capture_compare_flag, .o_timer_channel_counter);

/* test/tcf_timer_capture_flags_test.sv */
// self-checking bench for the capture flag timer
`timescale 1ns/1ns
`define CK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("mismatch %0t %h", $time, a); end end
module tcf_timer_capture_flags_test;
  reg i_clock = 1'b0, i_rst = 1'b1, i_standby = 1'b0;
  reg [5:0] i_count_enable = 6'h0;
  reg [383:0] i_general_reg = 384'h0;
  reg [23:0] i_capture_mode = 24'h0, i_capture_strobe = 24'h0, i_xfer_activate = 24'h0;
  reg [23:0] i_clear_suppress_select = 24'h0, ef = 24'h0;
  wire [7:0] i_wb_adr;
  wire [31:0] i_wb_dat, o_wb_dat;
  wire [3:0] i_wb_sel;
  wire i_wb_we, i_wb_cyc, i_wb_stb, o_wb_ack, o_irq;
  wire [23:0] o_event_request, o_capture_compare_flag;
  wire [95:0] o_timer_channel_counter;
  reg [31:0] q;
  integer fails = 0, compares = 0, seed = 32'h121a, k, t = 0;
  always #2 i_clock = ~i_clock;
  tcf_timer_capture_flags dut_u (.i_clock, .i_rst, .i_standby, .i_wb_adr, .i_wb_dat, .i_wb_sel,
    .i_wb_we, .i_wb_cyc, .i_wb_stb, .o_wb_dat, .o_wb_ack, .i_count_enable, .i_general_reg,
    .i_capture_mode, .i_capture_strobe, .i_xfer_activate, .i_clear_suppress_select,
    .o_event_request, .o_capture_compare_flag, .o_timer_channel_counter, .o_irq);
  tcf_host_model host_u (.i_clock, .i_ack(o_wb_ack), .i_rdat(o_wb_dat), .o_cyc(i_wb_cyc),
    .o_stb(i_wb_stb), .o_we(i_wb_we), .o_adr(i_wb_adr), .o_sel(i_wb_sel), .o_dat(i_wb_dat));
  task tick(input integer n); repeat (n) @(posedge i_clock); endtask
  task wr(input [7:0] a, input [31:0] d); host_u.xfer(a, 1'b1, 4'hF, d, q); endtask
  task rd(input [7:0] a, input [31:0] e); begin host_u.xfer(a, 1'b0, 4'hF, 0, q); `CK(q, e) end endtask
  task fin; begin t = t + 1; $display("test %0d done", t); end endtask
  task summarize;
    begin
      fails = fails + host_u.timeouts;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    tick(10);
    i_rst <= 1'b0;
    tick(1);
    rd(8'h00, 32'hC0);
    rd(8'h20, 32'h0);
    // capture everywhere; narrow channels keep C and D clear
    {i_capture_mode, i_capture_strobe} <= {24'hFFFFFF, 24'hFFFFFF};
    tick(1);
    i_capture_strobe <= 24'h0;
    tick(1);
    ef = 24'h33F33F;
    `CK(o_capture_compare_flag, ef)
    rd(8'h04, 32'hC3);
    wr(8'h40, 32'hFFFFFF);
    `CK(o_event_request, ef)
    `CK(o_irq, 1'b0)
    wr(8'h48, 32'hFFFFFF);
    `CK(o_irq, 1'b1)
    wr(8'h44, 32'hFFFFFF);
    `CK(o_irq, 1'b0)
    fin;
    // a zero write without a prior read of one is ignored
    wr(8'h00, 32'hC0);
    `CK(o_capture_compare_flag, ef)
    rd(8'h00, 32'hCF);
    wr(8'h00, 32'hC0);
    wr(8'h00, 32'hFF);
    ef[3:0] = 4'h0;
    `CK(o_capture_compare_flag, ef)
    fin;
    {i_clear_suppress_select, i_xfer_activate} <= {24'h001000, 24'h003000};
    tick(1);
    i_xfer_activate <= 24'h0;
    tick(1);
    ef[13] = 1'b0;
    `CK(o_capture_compare_flag, ef)
    // bit 14 is set and unsuppressed: its capture must beat the clear
    {i_capture_strobe, i_xfer_activate} <= {24'h006000, 24'h006000};
    tick(1);
    {i_capture_strobe, i_xfer_activate} <= 48'h0;
    tick(1);
    ef[13] = 1'b1;
    `CK(o_capture_compare_flag, ef)
    fin;
    // compare values a random way up the count
    i_capture_mode <= 24'h0;
    for (k = 0; k < 4; k = k + 1) i_general_reg[k*16+:16] <= 16'h1 + ($random(seed) & 7);
    i_count_enable <= 6'h01;
    tick(10);
    i_count_enable <= 6'h00;
    tick(1);
    ef[3:0] = 4'hF;
    `CK(o_capture_compare_flag, ef)
    rd(8'h20, 32'hA);
    host_u.xfer(8'h20, 1'b1, 4'h1, 32'h1234, q);
    rd(8'h20, 32'hA);
    wr(8'h20, 32'h1234);
    rd(8'h20, 32'h1234);
    fin;
    i_standby <= 1'b1;
    tick(1);
    i_standby <= 1'b0;
    tick(1);
    `CK(o_timer_channel_counter[15:0], 16'h0)
    i_rst <= 1'b1;
    tick(1);
    i_rst <= 1'b0;
    tick(1);
    `CK(o_capture_compare_flag, 24'h0)
    fin;
    summarize;
  end
endmodule // tcf_timer_capture_flags_test
